// ---- hw/port_ctl_map.svh ----
`ifndef PORT_CTL_MAP_SVH
`define PORT_CTL_MAP_SVH

// ==========================================================
// Register word indices on the plain register port
`define PCTL_ADDR_HIGH   4'h0
`define PCTL_ADDR_LOW    4'h1
`define PCTL_ADDR_STAT   4'h2

// ==========================================================
// Reset values and fixed codes
`define PCTL_HIGH_RST    16'h0000
`define PCTL_LOW_RST     8'h00
`define PCTL_RD_ZERO     16'h0000
`define PCTL_PAD_LOW     8'h00
`define PCTL_PAD_STAT    2'h0
`define PCTL_CNT_AUDIO   3'h1
`define PCTL_FMT_DSP     2'h3

`endif

// ---- hw/port_ctl_pkg.sv ----
package port_ctl_pkg;

    // ==========================================================
    // High control word, bit 15 down to bit 0
    typedef struct packed {
        logic       audioModeEnable;
        logic       rxSignExtend;
        logic       ignoreRxOverflow;
        logic       ignoreTxUnderrun;
        logic       audioMonoSelect;
        logic       underrunDataEnable;
        logic [1:0] audioFormatSelect;
        logic       framingEnable;
        logic       frameSyncDirection;
        logic       framePolarity;
        logic       masterSlaveSelectDrive;
        logic       framePulseWidth;
        logic [2:0] frameCountField;
    } ctrl_high_s;

    // ==========================================================
    // Low control word, bit 7 down to bit 0
    typedef struct packed {
        logic       portEnable;
        logic       masterSelect;
        logic       clockEdgeSelect;
        logic       slaveSelectEnable;
        logic       inputSamplePhase;
        logic       masterClockSourceSelect;
        logic [1:0] spare;
    } ctrl_low_s;

    // ==========================================================
    // Settings as the port really applies them
    typedef struct packed {
        logic       framingEnable;
        logic       frameSyncDirection;
        logic [2:0] frameCount;
        logic       samplePhase;
        logic       clockEdge;
        logic       slaveSelectEnable;
        logic       framePolarity;
        logic       framePulseWidth;
        logic       bitClockOe;
        logic       frameLineOe;
    } eff_s;

    // ==========================================================
    // State of the register side
    typedef struct packed {
        ctrl_high_s  high;
        ctrl_low_s   low;
        eff_s        eff;
        eff_s        hold;
        logic        reqToggle;
        logic [1:0]  ackSync;
        logic [1:0]  frameSync;
        logic [15:0] rdata;
    } main_s;

    // ==========================================================
    // State of the link side
    typedef struct packed {
        logic [1:0] rstSync;
        logic [1:0] reqSync;
        logic       reqSeen;
        eff_s       cfg;
    } link_s;

endpackage

// ---- hw/serial_port_audio_frame_control.sv ----
`timescale 1ns/1ns
// Behaviour
// - Clock source bit writable only while disabled
// - DSP mode: channel choice has no meaning
// - Audio mode forces framing, count, sample phase
// - Audio off: stored framing settings apply
// - Audio mode acts as clock edge zero
// - Framing on ignores slave select enable
`include "port_ctl_map.svh"

module serial_port_audio_frame_control
    import port_ctl_pkg::*;
(
    // Clock, reset, freeze
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        ce,
    // Register port
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output      logic [15:0] rdata,
    // Link side
    input  wire logic        linkClk,
    input  wire logic        frameLineIn,
    output      eff_s        linkCfg,
    output      logic        bitClockPinOe,
    output      logic        frameLineOe
);

    // ==========================================================
    // Register side and link side state
    main_s st;
    main_s next_st;
    eff_s  effNow;
    logic  isDsp;
    logic  busy;
    link_s lk;
    link_s next_lk;

    // Effective settings from the stored words
    always_comb
    begin
        isDsp = st.high.audioModeEnable
              && (st.high.audioFormatSelect == `PCTL_FMT_DSP);
        effNow = '0;
        if (st.high.audioModeEnable)
        begin
            effNow.framingEnable      = 1'b1;
            effNow.frameSyncDirection = st.low.masterSelect;
            effNow.frameCount         = `PCTL_CNT_AUDIO;
            effNow.samplePhase        = 1'b0;
            effNow.clockEdge          = 1'b0;
        end
        else
        begin
            effNow.framingEnable      = st.high.framingEnable;
            effNow.frameSyncDirection = st.high.frameSyncDirection;
            effNow.frameCount         = st.high.frameCountField;
            effNow.samplePhase        = st.low.inputSamplePhase;
            effNow.clockEdge          = st.low.clockEdgeSelect;
        end
        // Framed transfers never use slave select
        effNow.slaveSelectEnable = effNow.framingEnable
                                 ? 1'b0 : st.low.slaveSelectEnable;
        // Frame polarity forced to zero in DSP mode
        effNow.framePolarity   = isDsp ? 1'b0 : st.high.framePolarity;
        effNow.framePulseWidth = st.high.framePulseWidth;
        effNow.bitClockOe      = st.low.masterSelect;
        effNow.frameLineOe     = effNow.framingEnable
                               && effNow.frameSyncDirection;
    end

    // Register access, crossing request, pin sampling
    always_comb
    begin
        next_st = st;
        busy = (st.reqToggle != st.ackSync[1]);
        next_st.eff = effNow;
        next_st.ackSync = {st.ackSync[0], lk.reqSeen};
        next_st.frameSync = {st.frameSync[0], frameLineIn};
        // Offer a new setting once the last one landed
        if (!busy && (st.hold != st.eff))
        begin
            next_st.hold = st.eff;
            next_st.reqToggle = ~st.reqToggle;
        end
        if (wr && (addr == `PCTL_ADDR_HIGH))
        begin
            next_st.high = wdata;
        end
        if (wr && (addr == `PCTL_ADDR_LOW))
        begin
            next_st.low = wdata[7:0];
            // Source select frozen while the port runs
            if (st.low.portEnable)
            begin
                next_st.low.masterClockSourceSelect =
                    st.low.masterClockSourceSelect;
            end
        end
        next_st.rdata = `PCTL_RD_ZERO;
        if (rd)
        begin
            unique case (addr)
                `PCTL_ADDR_HIGH: next_st.rdata = st.high;
                `PCTL_ADDR_LOW:  next_st.rdata = {`PCTL_PAD_LOW, st.low};
                `PCTL_ADDR_STAT: next_st.rdata = {`PCTL_PAD_STAT,
                                                  st.frameSync[1], busy, st.eff};
                default:         next_st.rdata = `PCTL_RD_ZERO;
            endcase
        end
    end

    // Register side flops
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            st <= '0;
            st.high <= `PCTL_HIGH_RST;
            st.low <= `PCTL_LOW_RST;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Loads the held setting when the toggle arrives
    always_comb
    begin
        next_lk = lk;
        next_lk.rstSync = {lk.rstSync[0], srst};
        next_lk.reqSync = {lk.reqSync[0], st.reqToggle};
        if (lk.reqSync[1] != lk.reqSeen)
        begin
            next_lk.cfg = st.hold;    // Stable while request open
            next_lk.reqSeen = lk.reqSync[1];
        end
    end

    // Link side flops, reset taken through a synchroniser
    always_ff @(posedge linkClk)
    begin
        if (lk.rstSync[1])
        begin
            lk <= '0;
            lk.rstSync <= next_lk.rstSync;
        end
        else
        begin
            lk <= next_lk;
        end
    end

    // ==========================================================
    // Outputs straight from flops
    assign rdata = st.rdata;
    assign linkCfg = lk.cfg;
    assign bitClockPinOe = lk.cfg.bitClockOe;
    assign frameLineOe = lk.cfg.frameLineOe;

    // ==========================================================
    // Checks on the register side
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_src_lock;
        ce && wr && (addr == `PCTL_ADDR_LOW) && st.low.portEnable
        |=> st.low.masterClockSourceSelect
            == $past(st.low.masterClockSourceSelect);
    endproperty
    a_src_lock: assert property (p_src_lock)
        else $error("source select changed while enabled");

    property p_dsp_pol;
        ce && isDsp |=> !st.eff.framePolarity;
    endproperty
    a_dsp_pol: assert property (p_dsp_pol)
        else $error("channel choice used in DSP mode");

    property p_audio_force;
        ce && st.high.audioModeEnable
        |=> st.eff.framingEnable && (st.eff.frameCount == `PCTL_CNT_AUDIO)
            && !st.eff.samplePhase
            && (st.eff.frameSyncDirection == $past(st.low.masterSelect))
            && (st.eff.bitClockOe == $past(st.low.masterSelect));
    endproperty
    a_audio_force: assert property (p_audio_force)
        else $error("audio mode did not force framing");

    property p_audio_off;
        ce && !st.high.audioModeEnable
        |=> (st.eff.frameCount == $past(st.high.frameCountField))
            && (st.eff.framingEnable == $past(st.high.framingEnable))
            && (st.eff.samplePhase == $past(st.low.inputSamplePhase));
    endproperty
    a_audio_off: assert property (p_audio_off)
        else $error("stored framing not honoured");

    property p_edge;
        ce && st.high.audioModeEnable |=> !st.eff.clockEdge;
    endproperty
    a_edge: assert property (p_edge)
        else $error("clock edge not forced in audio mode");

    property p_ssel;
        ce && effNow.framingEnable |=> !st.eff.slaveSelectEnable;
    endproperty
    a_ssel: assert property (p_ssel)
        else $error("slave select used while framed");

    property p_reset;
        srst |=> (st.high == `PCTL_HIGH_RST) && (st.low == `PCTL_LOW_RST);
    endproperty
    a_reset: assert property (disable iff (1'b0) p_reset)
        else $error("control words not cleared by reset");

    property p_rw;
        ce && wr && (addr == `PCTL_ADDR_HIGH)
        ##1 ce && rd && (addr == `PCTL_ADDR_HIGH)
        |=> rdata == $past(wdata, 2);
    endproperty
    a_rw: assert property (p_rw)
        else $error("high word read back wrong");

    // ==========================================================
    // Checks on the register port timing and freeze
    // Read data stand only after a read
    property p_rd_idle;
        ce && !rd |=> rdata == `PCTL_RD_ZERO;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data stood without a read");

    // Unmapped words read as zero
    property p_unmapped;
        ce && rd && (addr > `PCTL_ADDR_STAT) |=> rdata == `PCTL_RD_ZERO;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped word read not zero");

    property p_low_rw;
        ce && wr && (addr == `PCTL_ADDR_LOW)
        ##1 ce && rd && (addr == `PCTL_ADDR_LOW)
        |=> rdata == {`PCTL_PAD_LOW, $past(st.low)};
    endproperty
    a_low_rw: assert property (p_low_rw)
        else $error("low word read back wrong");

    // Whole low word lands while the port is off
    property p_src_free;
        ce && wr && (addr == `PCTL_ADDR_LOW) && !st.low.portEnable
        |=> st.low == $past(wdata[7:0]);
    endproperty
    a_src_free: assert property (p_src_free)
        else $error("low word write refused while disabled");

    // Low clock enable holds words and read data
    property p_freeze;
        !ce
        |=> (st.high == $past(st.high)) && (st.low == $past(st.low))
            && (rdata == $past(rdata));
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");

    // ==========================================================
    // Checks on the crossing and the forced settings
    // Held word steady while the link may load it
    property p_hold_stable;
        ce && busy |=> st.hold == $past(st.hold);
    endproperty
    a_hold_stable: assert property (p_hold_stable)
        else $error("held setting changed during handshake");

    property p_ack_close;
        ce && $rose(busy) |-> ##[1:40] !busy;
    endproperty
    a_ack_close: assert property (p_ack_close)
        else $error("link handshake did not close");

    property p_audio_oe;
        ce && st.high.audioModeEnable
        |=> st.eff.frameLineOe == $past(st.low.masterSelect);
    endproperty
    a_audio_oe: assert property (p_audio_oe)
        else $error("frame line direction not set by master");

    property p_ssel_stored;
        ce && st.high.framingEnable |=> !st.eff.slaveSelectEnable;
    endproperty
    a_ssel_stored: assert property (p_ssel_stored)
        else $error("slave select kept with framing bit set");

    property p_edge_off;
        ce && !st.high.audioModeEnable
        |=> st.eff.clockEdge == $past(st.low.clockEdgeSelect);
    endproperty
    a_edge_off: assert property (p_edge_off)
        else $error("stored clock edge not honoured");

endmodule

// ---- tb/codec_model.sv ----
`timescale 1ns/1ns

module codec_model
(
    // Link clock
    input  wire logic linkClk,
    // Frame line
    input  wire logic frameLineOe,
    output      logic frameLine
);
    logic phase = 1'b0;

    // ==========================================================
    // Far side framing
    // Frame toggles each rising link edge while the far side owns the line
    always_ff @(posedge linkClk)
    begin
        phase <= ~phase;
    end

    // Released line sits at its pull-up level
    assign frameLine = frameLineOe ? 1'b1 : phase;
endmodule

// ---- tb/serial_port_audio_frame_control_tb.sv ----
`timescale 1ns/1ns
`include "port_ctl_map.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failCount++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); end end

module serial_port_audio_frame_control_tb
    import port_ctl_pkg::*;
;
    logic        mclk;
    logic        srst;
    logic        ce;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        linkClk;
    logic        frameLine;
    eff_s        linkCfg;
    logic        bitClockPinOe;
    logic        frameLineOe;
    logic [15:0] got;
    eff_s        e;
    int          failCount;
    int          checks;
    logic [15:0] hiTab [4] = '{16'h8000, 16'h8328, 16'h00E5, 16'h0012};
    logic [7:0]  loTab [4] = '{8'h78, 8'h20, 8'h38, 8'h50};

    // ==========================================================
    // Clocks, unrelated in phase
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial
    begin
        linkClk = 1'b0;
        #7;
        forever #32 linkClk = ~linkClk;
    end

    serial_port_audio_frame_control i_serial_port_audio_frame_control (
        .mclk(mclk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .linkClk(linkClk),
        .frameLineIn(frameLine), .linkCfg(linkCfg),
        .bitClockPinOe(bitClockPinOe), .frameLineOe(frameLineOe));

    codec_model i_codec_model (
        .linkClk(linkClk), .frameLineOe(frameLineOe), .frameLine(frameLine));

    // ==========================================================
    // Register access and checks
    task automatic conclude;
        $display("errors %0d checks %0d", failCount, checks);
        if (failCount == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wrReg(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rdReg(input logic [3:0] a, output logic [15:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge mclk);
    endtask

    task automatic chkReg(input logic [3:0] a, input logic [15:0] x, input string n);
        rdReg(a, got);
        `CHK(n, x, got)
    endtask

    // Bounded wait; two idle reads skip the gap between handshakes
    task automatic waitIdle;
        int idle;
        idle = 0;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < 100; i++)
        begin
            rdReg(`PCTL_ADDR_STAT, got);
            idle = (got[12] === 1'b0) ? idle + 1 : 0;
            if (idle == 2)
                return;
        end
        failCount++;
        conclude();
    endtask

    // Settings the port should apply
    function automatic eff_s expEff(input ctrl_high_s h, input ctrl_low_s l);
        eff_s r;
        logic a;
        a = h.audioModeEnable;
        r.framingEnable = a | h.framingEnable;
        r.frameSyncDirection = a ? l.masterSelect : h.frameSyncDirection;
        r.frameCount = a ? `PCTL_CNT_AUDIO : h.frameCountField;
        r.samplePhase = a ? 1'b0 : l.inputSamplePhase;
        r.clockEdge = a ? 1'b0 : l.clockEdgeSelect;
        r.slaveSelectEnable = r.framingEnable ? 1'b0 : l.slaveSelectEnable;
        r.framePolarity = (a && h.audioFormatSelect == `PCTL_FMT_DSP) ? 1'b0
                                                                     : h.framePolarity;
        r.framePulseWidth = h.framePulseWidth;
        r.bitClockOe = l.masterSelect;
        r.frameLineOe = a ? l.masterSelect : (h.framingEnable & h.frameSyncDirection);
        return r;
    endfunction

    // ==========================================================
    // Main sequence
    initial
    begin
        srst = 1'b1;
        ce = 1'b1;
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        failCount = 0;
        checks = 0;
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        chkReg(`PCTL_ADDR_HIGH, 16'h0000, "high rst");
        chkReg(`PCTL_ADDR_LOW, 16'h0000, "low rst");
        chkReg(4'h9, 16'h0000, "unmapped");
        `CHK("cfg rst", 12'h000, linkCfg)
        wrReg(4'hF, 16'h1234);
        @(posedge mclk);
        wrReg(`PCTL_ADDR_HIGH, 16'hFFFF);
        chkReg(`PCTL_ADDR_HIGH, 16'hFFFF, "high rw");
        wrReg(`PCTL_ADDR_LOW, 16'h0084);
        chkReg(`PCTL_ADDR_LOW, 16'h0084, "src set");
        wrReg(`PCTL_ADDR_LOW, 16'h0080);
        chkReg(`PCTL_ADDR_LOW, 16'h0084, "src locked");
        wrReg(`PCTL_ADDR_LOW, 16'h0000);
        chkReg(`PCTL_ADDR_LOW, 16'h0004, "src kept");
        wrReg(`PCTL_ADDR_LOW, 16'h0000);
        chkReg(`PCTL_ADDR_LOW, 16'h0000, "src clear");
        ce <= 1'b0;
        wrReg(`PCTL_ADDR_HIGH, 16'h5555);
        ce <= 1'b1;
        chkReg(`PCTL_ADDR_HIGH, 16'hFFFF, "frozen");
        for (int k = 0; k < 4; k++)
        begin
            wrReg(`PCTL_ADDR_HIGH, hiTab[k]);
            @(posedge mclk);
            wrReg(`PCTL_ADDR_LOW, {8'h00, loTab[k]});
            waitIdle();
            e = expEff(hiTab[k], loTab[k]);
            chkReg(`PCTL_ADDR_HIGH, hiTab[k], "high");
            rdReg(`PCTL_ADDR_STAT, got);
            `CHK("eff", e, got[11:0])
            if (e.frameLineOe)
                `CHK("frame line", 1'b1, got[13])
            `CHK("cfg", e, linkCfg)
            `CHK("bit clock oe", e.bitClockOe, bitClockPinOe)
            `CHK("frame oe", e.frameLineOe, frameLineOe)
        end
        conclude();
    end
endmodule
